// ---- rtl/wdog_pkg.sv ----
// Package: register map, field positions, reset values and timing counts
// for the watchdog block. Assumes a 32-bit classic Wishbone register bus.
package wdog_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 4'h0;
  localparam logic [ADDR_W-1:0] TIMEOUT_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] SERVICE_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 4'hc;

  // Control field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_RSTSEL_BIT = 1;
  localparam int unsigned CTRL_SLPSTOP_BIT = 2;
  localparam int unsigned CTRL_WAITSTOP_BIT = 3;

  // Status field positions
  localparam int unsigned STAT_FIRED_BIT = 0;
  localparam int unsigned STAT_LOCK_BIT  = 1;
  localparam int unsigned STAT_CNT_LSB   = 16;

  // Two-word refresh key sequence
  localparam logic [15:0] KEY_FIRST  = 16'h5555;
  localparam logic [15:0] KEY_SECOND = 16'haaaa;

  // Timing: one watchdog tick every TICK_US microseconds at 50 MHz
  localparam int unsigned CLK_MHZ     = 50;
  localparam int unsigned TICK_US     = 100;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;

  localparam logic [CNT_W-1:0] TIMEOUT_RST = 16'h0100;

endpackage

// ---- rtl/wdog_tick_if.sv ----
// Interface: tick and pause signals between tick generator and core.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface wdog_tick_if;
  logic pause;
  logic tick;
  modport gen  (input pause, output tick);
  modport core (output pause, input tick);
endinterface

// ---- rtl/wdog_tick_gen.sv ----
// Tick prescaler: one-cycle pulse every DIV cycles, frozen while paused.
// Assumes synchronous active-high reset and a free-running clock.
`timescale 1ns/10ps
module wdog_tick_gen #(
  parameter int unsigned DIV = wdog_pkg::TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  wdog_tick_if.gen  tk
);
  localparam int unsigned PW = $clog2(DIV + 1);

  typedef struct packed {
    logic [PW-1:0] cnt;
    logic          tick;
  } tick_state_t;

  tick_state_t st_ff;
  tick_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!tk.pause) begin
      if (st_ff.cnt == PW'(DIV - 1)) begin
        nxt_st.cnt  = '0;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tk.tick = st_ff.tick;

  tick_pause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tk.pause |=> !tk.tick) else $error("Tick while paused");

endmodule

// ---- rtl/wdog_top.sv ----
// Watchdog core: Wishbone register slave, down-counter and timeout outputs.
// Assumes low-power mode levels arrive from another domain (synchronised).
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module wdog_top #(
  parameter int unsigned TICK_DIV = wdog_pkg::TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        light_sleep_mode_i,
  input  wire logic        wait_mode_i,
  output logic             timeout_n_o,
  output logic             sys_rst_req_n_o
);

  typedef struct packed {
    logic                        en;
    logic                        rst_sel;
    logic                        slp_stop;
    logic                        wait_stop;
    logic                        locked;
    logic [wdog_pkg::CNT_W-1:0]  tmo;
    logic [wdog_pkg::CNT_W-1:0]  cnt;
    logic                        key1;
    logic                        fired;
    logic [1:0]                  slp_sync;
    logic [1:0]                  wait_sync;
    logic                        ack;
    logic [31:0]                 rdat;
    logic                        tmo_n;
    logic                        rst_n;
  } core_state_t;

  core_state_t st_ff;
  core_state_t nxt_st;
  wdog_tick_if tk ();

  wdog_tick_gen #(.DIV(TICK_DIV)) u_tick (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tk    (tk)
  );

  logic bus_req;
  logic wr_ctrl;
  logic wr_tmo;
  logic wr_svc;
  logic refresh;
  logic slp_lvl;
  logic wait_lvl;

  assign bus_req  = cyc_i && stb_i && !st_ff.ack;
  assign wr_ctrl  = bus_req && we_i && adr_i == wdog_pkg::CTRL_OFS
                    && sel_i[0];
  assign wr_tmo   = bus_req && we_i && adr_i == wdog_pkg::TIMEOUT_OFS
                    && (&sel_i[1:0]);
  assign wr_svc   = bus_req && we_i && adr_i == wdog_pkg::SERVICE_OFS
                    && (&sel_i[1:0]);
  // Refresh is the second word of the key pair, only while running
  assign refresh  = wr_svc && st_ff.key1 && st_ff.en
                    && dat_i[15:0] == wdog_pkg::KEY_SECOND;
  assign slp_lvl  = st_ff.slp_sync[1];
  assign wait_lvl = st_ff.wait_sync[1];

  // Counting pauses in each low-power mode independently
  assign tk.pause = !st_ff.en || st_ff.fired
                    || (st_ff.slp_stop && slp_lvl)
                    || (st_ff.wait_stop && wait_lvl);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.slp_sync  = {st_ff.slp_sync[0], light_sleep_mode_i};
    nxt_st.wait_sync = {st_ff.wait_sync[0], wait_mode_i};
    nxt_st.ack = bus_req;

    if (wr_ctrl) begin
      // Enable is sticky: a zero write never clears it
      nxt_st.en = st_ff.en | dat_i[wdog_pkg::CTRL_EN_BIT];
      if (!st_ff.locked) begin
        nxt_st.rst_sel   = dat_i[wdog_pkg::CTRL_RSTSEL_BIT];
        nxt_st.slp_stop  = dat_i[wdog_pkg::CTRL_SLPSTOP_BIT];
        nxt_st.wait_stop = dat_i[wdog_pkg::CTRL_WAITSTOP_BIT];
        nxt_st.locked    = 1'b1;
      end
      if (dat_i[wdog_pkg::CTRL_EN_BIT] && !st_ff.en) begin
        nxt_st.cnt = st_ff.tmo;
      end
    end
    if (wr_tmo) begin
      nxt_st.tmo = dat_i[wdog_pkg::CNT_W-1:0];
    end
    if (wr_svc) begin
      nxt_st.key1 = dat_i[15:0] == wdog_pkg::KEY_FIRST;
    end

    if (refresh && !st_ff.fired) begin
      nxt_st.cnt = st_ff.tmo;
    // A tick already in flight when a pause begins must not count
    end else if (tk.tick && !tk.pause && st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - wdog_pkg::CNT_W'(1);
    end

    // Counter at zero while running means the refresh was missed
    if (st_ff.en && st_ff.cnt == '0) begin
      nxt_st.fired = 1'b1;
    end
    // Output choice follows the programmed select; held until reset
    nxt_st.tmo_n = !(st_ff.fired && !st_ff.rst_sel);
    nxt_st.rst_n = !(st_ff.fired && st_ff.rst_sel);

    nxt_st.rdat = '0;
    if (bus_req && !we_i) begin
      unique case (adr_i)
        wdog_pkg::CTRL_OFS: begin
          nxt_st.rdat[wdog_pkg::CTRL_EN_BIT]       = st_ff.en;
          nxt_st.rdat[wdog_pkg::CTRL_RSTSEL_BIT]   = st_ff.rst_sel;
          nxt_st.rdat[wdog_pkg::CTRL_SLPSTOP_BIT]  = st_ff.slp_stop;
          nxt_st.rdat[wdog_pkg::CTRL_WAITSTOP_BIT] = st_ff.wait_stop;
        end
        wdog_pkg::TIMEOUT_OFS: begin
          nxt_st.rdat[wdog_pkg::CNT_W-1:0] = st_ff.tmo;
        end
        wdog_pkg::STATUS_OFS: begin
          nxt_st.rdat[wdog_pkg::STAT_FIRED_BIT] = st_ff.fired;
          nxt_st.rdat[wdog_pkg::STAT_LOCK_BIT]  = st_ff.locked;
          nxt_st.rdat[wdog_pkg::STAT_CNT_LSB +: wdog_pkg::CNT_W] =
            st_ff.cnt;
        end
        default: begin
          nxt_st.rdat = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff       <= '0;
      st_ff.tmo   <= wdog_pkg::TIMEOUT_RST;
      st_ff.tmo_n <= 1'b1;
      st_ff.rst_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dat_o           = st_ff.rdat;
  assign ack_o           = st_ff.ack;
  assign timeout_n_o     = st_ff.tmo_n;
  assign sys_rst_req_n_o = st_ff.rst_n;

  en_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.en |=> st_ff.en) else $error("Enable cleared");

  lock_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.locked |=> $stable(st_ff.rst_sel) && $stable(st_ff.slp_stop)
      && $stable(st_ff.wait_stop)) else $error("Locked bit changed");

  reload_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    refresh && !st_ff.fired |=> st_ff.cnt == $past(st_ff.tmo))
    else $error("Refresh did not reload");

  zero_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.en && st_ff.cnt == '0 |=> st_ff.fired)
    else $error("Zero count did not fire");

  out_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.fired |=> (st_ff.rst_sel ? !sys_rst_req_n_o && timeout_n_o
                                   : !timeout_n_o && sys_rst_req_n_o))
    else $error("Wrong timeout output");

  quiet_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_ff.fired ##1 !st_ff.fired |-> timeout_n_o && sys_rst_req_n_o)
    else $error("Output without timeout");

  pause_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.slp_stop && slp_lvl && !refresh && !wr_ctrl
      |=> $stable(st_ff.cnt)) else $error("Counted in sleep");

  pause_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.wait_stop && wait_lvl && !refresh && !wr_ctrl
      |=> $stable(st_ff.cnt)) else $error("Counted in wait");

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("Ack longer than one cycle");

  fired_c: cover property (@(posedge clk_i) disable iff (rst_i)
    st_ff.fired && st_ff.rst_sel);
  tmo_c: cover property (@(posedge clk_i) disable iff (rst_i)
    !timeout_n_o);
  refresh_c: cover property (@(posedge clk_i) disable iff (rst_i)
    refresh);
  sleep_c: cover property (@(posedge clk_i) disable iff (rst_i)
    st_ff.en && slp_lvl && st_ff.slp_stop);

endmodule

// ---- test/wdog_reset_sink.sv ----
// Partner model: reset logic and timeout consumer beyond the watchdog.
// Assumes active-low request levels on the same clock as the watchdog.
`timescale 1ns/10ps
module wdog_reset_sink (
  input  wire logic clk_i,
  input  wire logic clr_i,
  input  wire logic timeout_n_i,
  input  wire logic sys_rst_req_n_i,
  output logic      to_seen_o,
  output logic      rst_seen_o
);
  // Requests are latched so even a one-cycle assertion is remembered
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      to_seen_o  <= 1'b0;
      rst_seen_o <= 1'b0;
    end else begin
      if (timeout_n_i === 1'b0) begin
        to_seen_o <= 1'b1;
      end
      if (sys_rst_req_n_i === 1'b0) begin
        rst_seen_o <= 1'b1;
      end
    end
  end
endmodule

// ---- test/watchdog_timeout_reset_bench.sv ----
// Testbench: random timeouts, refresh, lock and pause scenarios.
// Assumes wdog_top with a short tick divider and the sink model beside it.
`timescale 1ns/10ps
module watchdog_timeout_reset_bench;
  localparam int DIV = 4;
  logic        clk_i;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        slp = 1'b0;
  logic        wt = 1'b0;
  logic        timeout_n_o;
  logic        sys_rst_req_n_o;
  logic        to_seen;
  logic        rst_seen;
  logic [31:0] rd;
  int          fail_count = 0;
  int          n_checks = 0;

  wdog_top #(.TICK_DIV(DIV)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o),
    .light_sleep_mode_i(slp), .wait_mode_i(wt),
    .timeout_n_o(timeout_n_o), .sys_rst_req_n_o(sys_rst_req_n_o));

  wdog_reset_sink u_sink (
    .clk_i(clk_i), .clr_i(rst_i), .timeout_n_i(timeout_n_o),
    .sys_rst_req_n_i(sys_rst_req_n_o), .to_seen_o(to_seen),
    .rst_seen_o(rst_seen));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Expected {timeout_n, reset_req_n} after firing for a given select
  function automatic logic [1:0] exp_out(input logic s);
    return s ? 2'b10 : 2'b01;
  endfunction

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    check(ack_o === 1'b1, "no bus ack");
    if (n >= 16) test_done();
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic refresh();
    wb(1'b1, wdog_pkg::SERVICE_OFS, {16'h0, wdog_pkg::KEY_FIRST});
    wb(1'b1, wdog_pkg::SERVICE_OFS, {16'h0, wdog_pkg::KEY_SECOND});
  endtask

  // Bounded wait; n equals lim when neither output fell
  task automatic wait_fire(input int lim, output int n);
    n = 0;
    while (timeout_n_o === 1'b1 && sys_rst_req_n_o === 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  initial begin
    int   t;
    int   n;
    logic s;
    void'($urandom(31));
    for (int i = 0; i < 4; i++) begin
      t = 6 + ($urandom % 16);
      s = (i < 2) ? i[0] : 1'($urandom % 2);
      do_reset();
      wb(1'b1, wdog_pkg::TIMEOUT_OFS, 32'(t));
      wb(1'b1, wdog_pkg::CTRL_OFS, {30'h0, s, 1'b1});
      for (int k = 0; k < 5; k++) begin
        refresh();
        wait_fire(t, n);
        check(n == t, "fired despite timely refresh");
      end
      // Disable and reselect after the first write must both be ignored
      wb(1'b1, wdog_pkg::CTRL_OFS, {30'h0, ~s, 1'b0});
      wb(1'b0, wdog_pkg::CTRL_OFS, 32'h0);
      check(rd[1] === s, "locked select changed");
      check(rd[0] === 1'b1, "enable was cleared");
      refresh();
      wait_fire(DIV * t + 6, n);
      check(n >= DIV * t - 5 && n < DIV * t + 6, "fire time off");
      @(posedge clk_i);
      check({timeout_n_o, sys_rst_req_n_o} === exp_out(s), "wrong pin");
      check({~to_seen, ~rst_seen} === exp_out(s), "sink saw wrong pin");
      wb(1'b0, wdog_pkg::STATUS_OFS, 32'h0);
      check(rd[1:0] === 2'h3, "status fired or lock flag");
    end
    for (int m = 0; m < 2; m++) begin
      do_reset();
      wb(1'b1, wdog_pkg::TIMEOUT_OFS, 32'h8);
      wb(1'b1, wdog_pkg::CTRL_OFS, 32'h1 | (32'h4 << m));
      refresh();
      @(posedge clk_i);
      slp <= (m == 0);
      wt  <= (m == 1);
      wait_fire(DIV * 24, n);
      check(n == DIV * 24, "counted while paused");
      @(posedge clk_i);
      slp <= (m == 1);
      wt  <= (m == 0);
      wait_fire(DIV * 8 + 8, n);
      check(n < DIV * 8 + 8, "other mode also paused");
      slp <= 1'b0;
      wt  <= 1'b0;
    end
    test_done();
  end
endmodule
